/* include/ipd_regs.vh */
`ifndef IPD_REGS_VH
`define IPD_REGS_VH
// ********************************
// Register byte addresses
// ********************************
`define IPD_POWER_CONTROL_REG_ADDR 10'h000
`define IPD_IPL_ADDR 10'h004
`define IPD_STAT_ADDR 10'h008
`define IPD_IE_ADDR 10'h00C
`define IPD_PRESERVE_ADDR 10'h010
// Priority register is word indexed: byte address is four times the index
`define IPD_IPH_INDEX 8'hB7
`define IPD_IPH_ADDR 10'h2DC
// ********************************
// Field positions
// ********************************
`define IPD_POWER_CONTROL_REG_IDLE 0
`define IPD_POWER_CONTROL_REG_PD 1
`define IPD_POWER_CONTROL_REG_GFA 2
`define IPD_POWER_CONTROL_REG_GFB 3
`define IPD_IE_EXA 0
`define IPD_IE_EXB 2
// ********************************
// Reset values and timing
// ********************************
`define IPD_POWER_CONTROL_REG_RST 8'h00
`define IPD_PRIO_RST 8'h00
`define IPD_RST_OSC_PERIODS 24
`define IPD_OSC_PER_CLK 1
`define IPD_RST_CYCLES (`IPD_RST_OSC_PERIODS / `IPD_OSC_PER_CLK)
`define IPD_STARTUP_CYCLES 1024
`endif

/* rtl/ipd_hold_mem.v */
`default_nettype none
// ********************************
// Small retained store, registered read
// ********************************
module ipd_hold_mem #(
    parameter AW = 2,
    parameter DW = 32
) (
    input wire aclk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    // No reset: contents survive power-down
    always @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // ipd_hold_mem
`default_nettype wire

/* rtl/ipd_power_ctrl.v */
// Function
// - Setting idle bit ends instruction, enters idle
// - Idle gates CPU clock, peripherals clocked
// - CPU state held during idle
// - Port pins frozen during idle
// - Address latch, fetch strobes high in idle
// - Enabled interrupt clears idle bit, serviced
// - Resume after instruction that entered idle
// - Two software flags, hardware clears them only on reset exit
// - Reset ends idle, two machine cycles
// - Power-down request stops oscillator after instruction
// - RAM and registers retained in power-down
// - Reset or external interrupt leaves power-down
// - Only enabled external irqs wake power-down
// - Low restarts oscillator, high completes exit
// - Either low restarts; first release completes
// - Both waking: higher priority serviced
// - Resume after instruction that entered power-down
//
// Design decision made here: register access over AXI4-Lite.
`include "ipd_regs.vh"
`default_nettype none
module ipd_power_ctrl #(
    parameter PORT_W = 32,
    parameter STARTUP_CYCLES = `IPD_STARTUP_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire hw_reset,
    input wire [9:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [9:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire instr_done,
    input wire irq_pending,
    input wire external_irq_a,
    input wire external_irq_b,
    input wire ext_irq_a_edge,
    input wire ext_irq_b_edge,
    input wire [PORT_W-1:0] port_in,
    input wire cpu_ale,
    input wire cpu_fetch,
    output reg [PORT_W-1:0] port_out,
    output reg address_latch_strobe,
    output reg program_fetch_strobe,
    output reg cpu_clk_en,
    output reg periph_clk_en,
    output reg osc_run,
    output reg cpu_reset,
    output reg wake_irq_req,
    output reg wake_irq_is_b,
    output reg [1:0] mode
);
    // ********************************
    // Modes
    // ********************************
    localparam M_RUN = 2'b00;
    localparam M_IDLE = 2'b01;
    localparam M_PD = 2'b10;
    localparam M_WAKE = 2'b11;
    localparam [15:0] START_N = STARTUP_CYCLES;
    localparam [4:0] RST_N = `IPD_RST_CYCLES;

    function [1:0] prio_level;
        input upper;
        input lower;
        prio_level = {upper, lower};
    endfunction

    reg [7:0] power_control_reg_q;
    reg [7:0] ipl_q;
    reg [7:0] iph_q;
    reg [7:0] ie_q;
    reg idle_req_q;
    reg pd_req_q;
    reg [15:0] start_cnt_q;
    reg [4:0] rst_cnt_q;
    reg aw_hold_q;
    reg w_hold_q;
    reg [9:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg a_low_q;
    reg b_low_q;
    reg ar_pend_q;
    reg [9:0] araddr_q;
    wire [31:0] mem_rdata;

    wire wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire wr_power_control_reg = wr_go && awaddr_q == `IPD_POWER_CONTROL_REG_ADDR && wstrb_q[0];
    wire wr_mem = wr_go && awaddr_q == `IPD_PRESERVE_ADDR;
    wire en_a = ie_q[`IPD_IE_EXA];
    wire en_b = ie_q[`IPD_IE_EXB];
    wire wake_a = en_a && (!external_irq_a || ext_irq_a_edge);
    wire wake_b = en_b && (!external_irq_b || ext_irq_b_edge);
    wire [1:0] lvl_a = prio_level(iph_q[0], ipl_q[0]);
    wire [1:0] lvl_b = prio_level(iph_q[2], ipl_q[2]);
    // Done on the last required edge, so exactly RST_N edges of reset suffice
    wire rst_done = rst_cnt_q >= RST_N - 5'd1;

    ipd_hold_mem #(.AW(2), .DW(32)) u_mem (
        .aclk(aclk),
        .we(wr_mem),
        .waddr(2'b00),
        .wdata(wdata_q),
        .raddr(2'b00),
        .rdata(mem_rdata)
    );

    // ********************************
    // AXI4-Lite write path
    // ********************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 10'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_q)
                    `IPD_POWER_CONTROL_REG_ADDR, `IPD_IPL_ADDR, `IPD_IPH_ADDR,
                    `IPD_IE_ADDR, `IPD_PRESERVE_ADDR, `IPD_STAT_ADDR: begin
                        s_axi_bresp <= 2'b00;
                    end
                    default: begin
                        s_axi_bresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ********************************
    // AXI4-Lite read path
    // ********************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
            ar_pend_q <= 1'b0;
            araddr_q <= 10'h000;
        end else begin
            s_axi_arready <= !ar_pend_q && !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                ar_pend_q <= 1'b1;
                araddr_q <= s_axi_araddr;
            end
            // Extra cycle lets the store's registered read settle
            if (ar_pend_q) begin
                ar_pend_q <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (araddr_q)
                    `IPD_POWER_CONTROL_REG_ADDR: s_axi_rdata <= {24'h000000, power_control_reg_q};
                    `IPD_IPL_ADDR: s_axi_rdata <= {24'h000000, 2'b00, ipl_q[5:0]};
                    `IPD_IPH_ADDR: s_axi_rdata <= {24'h000000, 2'b00, iph_q[5:0]};
                    `IPD_IE_ADDR: s_axi_rdata <= {24'h000000, ie_q};
                    `IPD_STAT_ADDR: s_axi_rdata <= {28'h0000000, osc_run, cpu_clk_en, mode};
                    `IPD_PRESERVE_ADDR: s_axi_rdata <= mem_rdata;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ********************************
    // Power mode sequencer
    // ********************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            power_control_reg_q <= `IPD_POWER_CONTROL_REG_RST;
            ipl_q <= `IPD_PRIO_RST;
            iph_q <= `IPD_PRIO_RST;
            ie_q <= 8'h00;
            idle_req_q <= 1'b0;
            pd_req_q <= 1'b0;
            mode <= M_RUN;
            start_cnt_q <= 16'h0000;
            rst_cnt_q <= 5'h00;
            a_low_q <= 1'b0;
            b_low_q <= 1'b0;
            cpu_reset <= 1'b0;
            wake_irq_req <= 1'b0;
            wake_irq_is_b <= 1'b0;
        end else begin
            wake_irq_req <= 1'b0;
            // Flags change by software write; a reset exit from idle or power-down clears them
            if (wr_power_control_reg) begin
                power_control_reg_q <= wdata_q[7:0];
                idle_req_q <= wdata_q[`IPD_POWER_CONTROL_REG_IDLE];
                pd_req_q <= wdata_q[`IPD_POWER_CONTROL_REG_PD];
            end
            if (wr_go && awaddr_q == `IPD_IPL_ADDR && wstrb_q[0]) ipl_q <= wdata_q[7:0];
            if (wr_go && awaddr_q == `IPD_IPH_ADDR && wstrb_q[0]) iph_q <= wdata_q[7:0];
            if (wr_go && awaddr_q == `IPD_IE_ADDR && wstrb_q[0]) ie_q <= wdata_q[7:0];
            // Reset counted every cycle hw_reset is held, oscillator running or not
            if (hw_reset) begin
                rst_cnt_q <= rst_done ? rst_cnt_q : rst_cnt_q + 5'd1;
            end else begin
                rst_cnt_q <= 5'h00;
            end
            cpu_reset <= hw_reset && rst_done;
            case (mode)
                M_RUN: begin
                    if (instr_done && pd_req_q) begin
                        mode <= M_PD;
                        pd_req_q <= 1'b0;
                    end else if (instr_done && idle_req_q) begin
                        mode <= M_IDLE;
                        idle_req_q <= 1'b0;
                    end
                end
                M_IDLE: begin
                    if (hw_reset && rst_done) begin
                        mode <= M_RUN;
                        power_control_reg_q <= `IPD_POWER_CONTROL_REG_RST;
                    end else if (irq_pending) begin
                        mode <= M_RUN;
                        power_control_reg_q[`IPD_POWER_CONTROL_REG_IDLE] <= 1'b0;
                    end
                end
                M_PD: begin
                    if (hw_reset) begin
                        mode <= M_WAKE;
                    end else if (wake_a || wake_b) begin
                        mode <= M_WAKE;
                        a_low_q <= wake_a;
                        b_low_q <= wake_b;
                    end
                    start_cnt_q <= 16'h0000;
                end
                M_WAKE: begin
                    start_cnt_q <= (start_cnt_q >= START_N) ? start_cnt_q :
                        start_cnt_q + 16'd1;
                    a_low_q <= a_low_q | wake_a;
                    b_low_q <= b_low_q | wake_b;
                    if (hw_reset && rst_done && start_cnt_q >= START_N) begin
                        mode <= M_RUN;
                        power_control_reg_q <= `IPD_POWER_CONTROL_REG_RST;
                    end else if (start_cnt_q >= START_N && ((a_low_q && external_irq_a) ||
                        (b_low_q && external_irq_b))) begin
                        mode <= M_RUN;
                        power_control_reg_q[`IPD_POWER_CONTROL_REG_PD] <= 1'b0;
                        wake_irq_req <= 1'b1;
                        // Equal levels keep the fixed order, pin a first
                        wake_irq_is_b <= b_low_q && (!a_low_q || lvl_b > lvl_a);
                        a_low_q <= 1'b0;
                        b_low_q <= 1'b0;
                    end
                end
                default: mode <= M_RUN;
            endcase
        end
    end

    // ********************************
    // Clock gates and frozen pins
    // ********************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            cpu_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            osc_run <= 1'b1;
            port_out <= {PORT_W{1'b0}};
            address_latch_strobe <= 1'b1;
            program_fetch_strobe <= 1'b1;
        end else begin
            // CPU state holds because its clock is gated
            cpu_clk_en <= (mode == M_RUN);
            periph_clk_en <= (mode == M_RUN) || (mode == M_IDLE);
            osc_run <= (mode != M_PD);
            if (mode == M_RUN) begin
                port_out <= port_in;
                address_latch_strobe <= cpu_ale;
                program_fetch_strobe <= cpu_fetch;
            end else begin
                address_latch_strobe <= 1'b1;
                program_fetch_strobe <= 1'b1;
            end
            // Else port_out keeps its value: frozen
        end
    end
endmodule // ipd_power_ctrl
`default_nettype wire

/* sim/ipd_power_ctrl_assertions.sv */
`default_nettype none
module ipd_power_ctrl_assertions #(
    parameter PORT_W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic hw_reset,
    input wire logic irq_pending,
    input wire logic external_irq_a,
    input wire logic external_irq_b,
    input wire logic ext_irq_a_edge,
    input wire logic ext_irq_b_edge,
    input wire logic [PORT_W-1:0] port_out,
    input wire logic address_latch_strobe,
    input wire logic program_fetch_strobe,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic osc_run,
    input wire logic wake_irq_req,
    input wire logic cpu_reset,
    input wire logic [1:0] mode
);
    timeunit 1ns;
    timeprecision 1ps;
    wire quiet = external_irq_a && external_irq_b && !ext_irq_a_edge && !ext_irq_b_edge
        && !hw_reset;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Two cycles in a mode so registered outputs have caught up
    sequence s_idle2; mode == 2'd1 ##1 mode == 2'd1; endsequence
    sequence s_pd2; mode == 2'd2 ##1 mode == 2'd2; endsequence
    chk_idle_strobes: assert property (s_idle2 |-> address_latch_strobe && program_fetch_strobe)
        else $error("strobe low in idle");
    chk_idle_clocks: assert property (s_idle2 |-> !cpu_clk_en && periph_clk_en)
        else $error("clock enables wrong in idle");
    chk_port_frozen: assert property (s_idle2 |-> $stable(port_out))
        else $error("port moved in idle");
    chk_pd_osc: assert property (s_pd2 |-> !osc_run)
        else $error("oscillator runs in power-down");
    chk_idle_exit: assert property (mode == 2'd1 && irq_pending |-> ##[1:3] mode == 2'd0)
        else $error("idle not ended by interrupt");
    chk_pd_stays: assert property ((mode == 2'd2 && quiet)[*3] |=> mode == 2'd2)
        else $error("power-down left without waker");
    chk_wake_pulse: assert property (wake_irq_req |=> !wake_irq_req)
        else $error("wake request not a pulse");
    chk_wake_osc: assert property (s_pd2 ##1 mode == 2'd3 |-> ##[0:2] osc_run)
        else $error("oscillator not restarted");
    chk_run_clocks: assert property ((mode == 2'd0 && !hw_reset)[*2] |-> cpu_clk_en && osc_run)
        else $error("clocks stopped in run");
    chk_reset_source: assert property (cpu_reset |-> $past(hw_reset))
        else $error("core reset without reset pin");
endmodule // ipd_power_ctrl_assertions
bind ipd_power_ctrl ipd_power_ctrl_assertions #(.PORT_W(PORT_W)) chk_u (.*);
`default_nettype wire

/* sim/ipd_wake_src.sv */
`default_nettype none
module ipd_wake_src (
    input wire logic aclk,
    input wire logic edge_mode,
    output var logic external_irq_a,
    output var logic external_irq_b,
    output var logic ext_irq_a_edge,
    output var logic ext_irq_b_edge,
    output var logic hw_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    logic a_q = 1'b1;
    logic b_q = 1'b1;
    initial begin
        {external_irq_a, external_irq_b} = 2'b11;
        {ext_irq_a_edge, ext_irq_b_edge, hw_reset} = 3'b000;
    end
    // Falling edges flagged only while pins are edge-configured
    always @(posedge aclk) begin
        a_q <= external_irq_a;
        b_q <= external_irq_b;
        ext_irq_a_edge <= edge_mode && a_q && !external_irq_a;
        ext_irq_b_edge <= edge_mode && b_q && !external_irq_b;
    end
    task automatic pin(input bit sel, input logic lvl);
        @(posedge aclk);
        if (sel) external_irq_b <= lvl;
        else external_irq_a <= lvl;
    endtask
    task automatic pulse_reset(input int cycles);
        @(posedge aclk);
        hw_reset <= 1'b1;
        repeat (cycles) @(posedge aclk);
        hw_reset <= 1'b0;
    endtask
endmodule // ipd_wake_src
`default_nettype wire

/* sim/idle_powerdown_control_tb_top.sv */
`include "ipd_regs.vh"
`default_nettype none
module idle_powerdown_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STARTUP = 8;
    logic aclk, aresetn, hw_reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, port_in, port_out, d, pv, po;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, mode, r;
    logic instr_done, irq_pending, external_irq_a, external_irq_b, ext_irq_a_edge;
    logic ext_irq_b_edge, cpu_ale, cpu_fetch, address_latch_strobe, program_fetch_strobe;
    logic cpu_clk_en, periph_clk_en, osc_run, cpu_reset, wake_irq_req, wake_irq_is_b, edge_mode;
    logic [31:0] rs = 32'h0000000B;
    int n_mismatch = 0;
    int total_checks = 0;
    int n;
    int exp_q[$];
    ipd_power_ctrl #(.STARTUP_CYCLES(STARTUP)) dut_u (.*);
    ipd_wake_src src_u (.*);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Live port traffic, so a frozen output really has something to ignore
    always @(posedge aclk) begin
        rs <= xs(rs);
        port_in <= rs;
        cpu_ale <= rs[3];
        cpu_fetch <= rs[7];
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] v);
        int k = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && k < 50);
        s_axi_bready <= 1'b0;
        chk(k < 50, 1'b1, "write timeout");
        chk(s_axi_bresp, 2'b00, "bresp");
    endtask
    task automatic rd(input logic [9:0] a);
        int k = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && k < 50);
        s_axi_rready <= 1'b0;
        chk(k < 50, 1'b1, "read timeout");
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic wait_mode(input logic [1:0] m);
        int k = 0;
        while (mode !== m && k < 2000) begin
            @(posedge aclk);
            k++;
        end
        chk(mode, m, "mode");
    endtask
    task automatic step();
        @(posedge aclk);
        instr_done <= 1'b1;
        @(posedge aclk);
        instr_done <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("TB: checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        $display("Error %0t: watchdog expired", $time);
        end_of_test();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {instr_done, irq_pending, edge_mode, cpu_ale, cpu_fetch} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, port_in} = '0;
        s_axi_wstrb = 4'hF;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`IPD_POWER_CONTROL_REG_ADDR);
        chk(d, {24'h0, `IPD_POWER_CONTROL_REG_RST}, "power_control_reg reset");
        rd(`IPD_IPH_ADDR);
        chk(d, {24'h0, `IPD_PRIO_RST}, "prio reset");
        wr(`IPD_IPH_ADDR, 32'hFF);
        rd(`IPD_IPH_ADDR);
        chk(d, 32'h3F, "prio rw");
        rd(10'h040);
        chk(r, 2'b10, "unmapped resp");
        chk(d, 32'h0, "unmapped data");
        $display("TB: register test done");
        wr(`IPD_POWER_CONTROL_REG_ADDR, 32'h0D);
        step();
        wait_mode(2'd1);
        @(posedge aclk);
        po = port_out;
        chk({address_latch_strobe, program_fetch_strobe, cpu_clk_en}, 3'b110, "idle outs");
        repeat (5) @(posedge aclk);
        chk(port_out, po, "port frozen");
        irq_pending <= 1'b1;
        wait_mode(2'd0);
        irq_pending <= 1'b0;
        rd(`IPD_POWER_CONTROL_REG_ADDR);
        chk(d, 32'h0C, "flags kept");
        wr(`IPD_POWER_CONTROL_REG_ADDR, 32'h01);
        step();
        wait_mode(2'd1);
        src_u.pulse_reset(`IPD_RST_CYCLES);
        wait_mode(2'd0);
        $display("TB: idle test done");
        pv = rs;
        wr(`IPD_PRESERVE_ADDR, pv);
        for (int k = 0; k < 2; k++) begin
            edge_mode <= k[0];
            exp_q.push_back(k);
            wr(`IPD_IE_ADDR, 32'h05);
            wr(`IPD_IPH_ADDR, k ? 32'h04 : 32'h01);
            wr(`IPD_POWER_CONTROL_REG_ADDR, 32'h02);
            step();
            wait_mode(2'd2);
            @(posedge aclk);
            chk(osc_run, 1'b0, "osc stopped");
            src_u.pin(1, 1'b0);
            wait_mode(2'd3);
            src_u.pin(0, 1'b0);
            repeat (STARTUP + 4) @(posedge aclk);
            src_u.pin(1, 1'b1);
            n = 0;
            while (wake_irq_req !== 1'b1 && n < 100) begin
                @(posedge aclk);
                n++;
            end
            chk(n < 100, 1'b1, "wake timeout");
            chk(wake_irq_is_b, exp_q.pop_front(), "wake source");
            src_u.pin(0, 1'b1);
            wait_mode(2'd0);
        end
        rd(`IPD_PRESERVE_ADDR);
        chk(d, pv, "retained word");
        wr(`IPD_IE_ADDR, 32'h00);
        wr(`IPD_POWER_CONTROL_REG_ADDR, 32'h02);
        step();
        wait_mode(2'd2);
        src_u.pin(0, 1'b0);
        repeat (20) @(posedge aclk);
        chk(mode, 2'd2, "disabled pin");
        src_u.pin(0, 1'b1);
        src_u.pulse_reset(`IPD_RST_CYCLES);
        wait_mode(2'd0);
        $display("TB: power-down test done");
        end_of_test();
    end
endmodule // idle_powerdown_control_tb_top
`default_nettype wire
